// ### rtl/gcms_top.sv
// The strobed register port is this design's own decision.
module gcms_top #(
	parameter int          MODULATOR_PERIOD_CLKS  = gcms_pkg::MODULATOR_PERIOD_CLKS,
	parameter logic [19:0] FIRST_MODULATOR_PERIOD [14] = gcms_pkg::FIRST_MODULATOR_PERIOD_DEF
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [7:0]  addr,
	input  wire logic [7:0]  wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [7:0]  rdata,
	input  wire logic        conv_clk,
	input  wire logic        start_pin,
	input  wire logic        raw_valid,
	input  wire logic [23:0] raw_data,
	output logic      [2:0]  amp_gain,
	output logic      [3:0]  excitation_magnitude,
	output logic      [3:0]  source_one_route,
	output logic      [3:0]  source_two_route,
	output logic             bias_level_sel,
	output logic      [6:0]  bias_pin_connect,
	output logic      [2:0]  monitor_select,
	output logic             temp_sensor_sel,
	output logic             inputs_disconnect,
	output logic             chop_polarity,
	output logic             result_ready
);

	typedef struct packed {
		logic [7:0]  gain;
		logic [7:0]  rate;
		logic [7:0]  exc1;
		logic [7:0]  exc2;
		logic [7:0]  bias;
		logic [7:0]  sysc;
		logic [7:0]  rdata;
		logic        temp_sel;
		logic        go_tog;
		logic        halt_tog;
		logic        ready;
		logic        busy_s1;
		logic        busy_s2;
		logic        rt_s1;
		logic        rt_s2;
		logic        rt_s3;
		logic [23:0] result;
	} gcms_sys_s;

	typedef struct packed {
		gcms_pkg::gcms_seq_e    st;
		logic [3:0]             pre;
		logic [19:0]            cnt;
		logic                   pol;
		logic [23:0]            prev;
		logic [23:0]            last;
		gcms_pkg::gcms_result_s res;
		gcms_pkg::gcms_cfg_s    cfg;
		logic                   busy;
		logic [2:0]             go_s;
		logic [2:0]             halt_s;
		logic [2:0]             pin_s;
	} gcms_conv_s;

	gcms_sys_s  s_q;
	gcms_sys_s  s_d;
	gcms_conv_s c_q;
	gcms_conv_s c_d;
	logic [1:0] crst_q;
	logic       crst_n;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	// ---------------- system clock domain ----------------
	always_comb begin
		s_d = s_q;
		s_d.busy_s1 = c_q.busy;
		s_d.busy_s2 = s_q.busy_s1;
		s_d.rt_s1 = c_q.res.toggle;
		s_d.rt_s2 = s_q.rt_s1;
		s_d.rt_s3 = s_q.rt_s2;
		s_d.rdata = 8'h00;
		if (wr) begin
			if (hit(addr, gcms_pkg::ADDR_GAIN)) begin
				s_d.gain = wdata;
			end
			if (hit(addr, gcms_pkg::ADDR_RATE)) begin
				s_d.rate = wdata;
			end
			if (hit(addr, gcms_pkg::ADDR_EXC1)) begin
				s_d.exc1 = wdata;
			end
			if (hit(addr, gcms_pkg::ADDR_EXC2)) begin
				// equal routes are accepted as is
				s_d.exc2 = wdata;
			end
			if (hit(addr, gcms_pkg::ADDR_BIAS)) begin
				s_d.bias = wdata;
			end
			if (hit(addr, gcms_pkg::ADDR_SYS)) begin
				s_d.sysc = wdata;
			end
			if (hit(addr, gcms_pkg::ADDR_CMD)) begin
				s_d.go_tog = s_q.go_tog ^ wdata[gcms_pkg::CMD_START_BIT];
				s_d.halt_tog = s_q.halt_tog ^ wdata[gcms_pkg::CMD_STOP_BIT];
			end
		end
		if (rd) begin
			case (1'b1)
				hit(addr, gcms_pkg::ADDR_GAIN): s_d.rdata = s_q.gain;
				hit(addr, gcms_pkg::ADDR_RATE): s_d.rdata = s_q.rate;
				hit(addr, gcms_pkg::ADDR_EXC1): s_d.rdata = s_q.exc1;
				hit(addr, gcms_pkg::ADDR_EXC2): s_d.rdata = s_q.exc2;
				hit(addr, gcms_pkg::ADDR_BIAS): s_d.rdata = s_q.bias;
				hit(addr, gcms_pkg::ADDR_SYS):  s_d.rdata = s_q.sysc;
				hit(addr, gcms_pkg::ADDR_STAT): begin
					s_d.rdata[gcms_pkg::STAT_READY_BIT] = s_q.ready;
					s_d.rdata[gcms_pkg::STAT_BUSY_BIT] = s_q.busy_s2;
					s_d.ready = 1'b0;
				end
				hit(addr, gcms_pkg::ADDR_RES2): s_d.rdata = s_q.result[23:16];
				hit(addr, gcms_pkg::ADDR_RES1): s_d.rdata = s_q.result[15:8];
				hit(addr, gcms_pkg::ADDR_RES0): s_d.rdata = s_q.result[7:0];
				default: s_d.rdata = 8'h00;
			endcase
		end
		// result word is held in the converter domain until the next toggle
		if (s_q.rt_s3 != s_q.rt_s2) begin
			s_d.result = c_q.res.word;
			s_d.ready = 1'b1;
		end
		s_d.temp_sel = (s_d.sysc[gcms_pkg::MON_LSB +: 3] == gcms_pkg::MON_TEMP);
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_q <= '0;
			s_q.gain <= gcms_pkg::RST_GAIN;
			s_q.rate <= gcms_pkg::RST_RATE;
			s_q.exc1 <= gcms_pkg::RST_EXC1;
			s_q.exc2 <= gcms_pkg::RST_EXC2;
			s_q.bias <= gcms_pkg::RST_BIAS;
			s_q.sysc <= gcms_pkg::RST_SYS;
		end else begin
			s_q <= s_d;
		end
	end

	assign rdata                = s_q.rdata;
	assign amp_gain             = s_q.gain[2:0];
	assign excitation_magnitude = s_q.exc1[3:0];
	assign source_one_route     = s_q.exc2[3:0];
	assign source_two_route     = s_q.exc2[7:4];
	assign bias_level_sel       = s_q.bias[gcms_pkg::BIAS_LEVEL_BIT];
	assign bias_pin_connect     = s_q.bias[6:0];
	assign monitor_select       = s_q.sysc[gcms_pkg::MON_LSB +: 3];
	assign temp_sensor_sel      = s_q.temp_sel;
	assign inputs_disconnect    = s_q.temp_sel;
	assign result_ready         = s_q.ready;

	// ---------------- converter clock domain ----------------
	always_ff @(posedge conv_clk) begin
		crst_q <= {crst_q[0], rst_n};
	end
	assign crst_n = crst_q[1];

	logic [19:0] first_cnt;
	logic [19:0] target;
	logic [11:0] delay_modulator_period;
	logic [3:0]  rate_idx;
	logic        tick;
	logic        go_ev;
	logic        halt_ev;
	logic        pin_ev;
	logic [23:0] corr;
	logic [24:0] sum;

	always_comb begin
		rate_idx = (c_q.cfg.rate > gcms_pkg::LAST_RATE) ? gcms_pkg::LAST_RATE : c_q.cfg.rate;
		first_cnt = FIRST_MODULATOR_PERIOD[rate_idx];
		delay_modulator_period = gcms_pkg::DELAY_BASE_MODULATOR_PERIOD << c_q.cfg.delay;
		// delay counted once per half of the chopped pair
		target = ((c_q.st == gcms_pkg::GCMS_FIRST) ? first_cnt : {1'b0, first_cnt[19:1]})
			+ {7'h00, delay_modulator_period, 1'b0};
		tick = (c_q.pre == 4'(MODULATOR_PERIOD_CLKS - 1));
		go_ev = c_q.go_s[2] != c_q.go_s[1];
		halt_ev = c_q.halt_s[2] != c_q.halt_s[1];
		pin_ev = c_q.pin_s[1] & ~c_q.pin_s[2];
		corr = c_q.pol ? 24'(-raw_data) : raw_data;
		sum = {c_q.last[23], c_q.last} + {c_q.prev[23], c_q.prev};
	end

	always_comb begin
		c_d = c_q;
		c_d.go_s = {c_q.go_s[1:0], s_q.go_tog};
		c_d.halt_s = {c_q.halt_s[1:0], s_q.halt_tog};
		c_d.pin_s = {c_q.pin_s[1:0], start_pin};
		c_d.pre = tick ? 4'h0 : c_q.pre + 4'h1;
		case (c_q.st)
			gcms_pkg::GCMS_IDLE: begin
				c_d.pre = 4'h0;
			end
			gcms_pkg::GCMS_FIRST, gcms_pkg::GCMS_NEXT: begin
				if (raw_valid) begin
					c_d.prev = c_q.last;
					c_d.last = corr;
					if (c_q.cfg.chop) begin
						c_d.pol = ~c_q.pol;
					end else begin
						c_d.res.word = raw_data;
						c_d.res.toggle = ~c_q.res.toggle;
					end
				end
				if (c_q.cfg.chop && tick) begin
					if (c_q.cnt == target - 20'h1) begin
						c_d.res.word = sum[24:1];
						c_d.res.toggle = ~c_q.res.toggle;
						c_d.cnt = 20'h0;
						c_d.st = gcms_pkg::GCMS_NEXT;
					end else begin
						c_d.cnt = c_q.cnt + 20'h1;
					end
				end
			end
			default: c_d.st = gcms_pkg::GCMS_IDLE;
		endcase
		if (halt_ev) begin
			c_d.st = gcms_pkg::GCMS_IDLE;
		end
		// config is sampled at the start request; host keeps it still while busy
		if (go_ev || pin_ev) begin
			c_d.st = gcms_pkg::GCMS_FIRST;
			c_d.cnt = 20'h0;
			c_d.pre = 4'h0;
			c_d.pol = 1'b0;
			c_d.prev = 24'h000000;
			c_d.last = 24'h000000;
			c_d.cfg.chop = s_q.rate[gcms_pkg::RATE_CHOP_BIT];
			c_d.cfg.rate = s_q.rate[3:0];
			c_d.cfg.delay = s_q.gain[gcms_pkg::DELAY_LSB +: 3];
		end
		c_d.busy = (c_d.st != gcms_pkg::GCMS_IDLE);
	end

	always_ff @(posedge conv_clk) begin
		if (!crst_n) begin
			c_q <= '0;
			c_q.st <= gcms_pkg::GCMS_IDLE;
		end else begin
			c_q <= c_d;
		end
	end

	assign chop_polarity = c_q.pol;

	// ---------------- checks ----------------
	sequence start_seen;
		pin_ev || go_ev;
	endsequence

	sequence chop_sample;
		c_q.st != gcms_pkg::GCMS_IDLE && c_q.cfg.chop && raw_valid && !go_ev && !pin_ev;
	endsequence

	property start_begins;
		@(posedge conv_clk) disable iff (!crst_n)
		start_seen |=> c_q.st == gcms_pkg::GCMS_FIRST && c_q.cnt == 20'h0 && !c_q.pol;
	endproperty

	property swap_each;
		@(posedge conv_clk) disable iff (!crst_n)
		chop_sample |=> c_q.pol != $past(c_q.pol);
	endproperty

	start_trigger_a: assert property (start_begins)
		else $error("start did not begin a first conversion");

	polarity_swap_a: assert property (swap_each)
		else $error("polarity did not reverse on a chopped conversion");

	chop_off_a: assert property (@(posedge conv_clk) disable iff (!crst_n)
		!c_q.cfg.chop && !start_pin && !c_q.pin_s[0] |=> $stable(c_q.pol) || $past(go_ev))
		else $error("polarity moved with chop disabled");

	modulator_period_tick_a: assert property (@(posedge conv_clk) disable iff (!crst_n)
		c_q.st != gcms_pkg::GCMS_IDLE && c_q.pre == 4'h0 && !go_ev && !pin_ev && !halt_ev
		|=> c_q.pre == 4'(1 % MODULATOR_PERIOD_CLKS) ##1 c_q.pre == 4'(2 % MODULATOR_PERIOD_CLKS))
		else $error("modulator prescaler out of step");

	result_time_a: assert property (@(posedge conv_clk) disable iff (!crst_n)
		c_q.cfg.chop && c_q.st == gcms_pkg::GCMS_FIRST && !go_ev && !pin_ev && !halt_ev
		&& $changed(c_d.res.toggle) |-> tick && c_q.cnt == FIRST_MODULATOR_PERIOD[rate_idx]
		+ {7'h00, delay_modulator_period, 1'b0} - 20'h1)
		else $error("first chopped result at wrong count");

	average_a: assert property (@(posedge conv_clk) disable iff (!crst_n)
		c_q.cfg.chop && $changed(c_q.res.toggle) && !$past(raw_valid)
		|-> 25'({c_q.res.word, 1'b0}) == {$past(c_q.last[23]), $past(c_q.last)}
		+ {$past(c_q.prev[23]), $past(c_q.prev)} || c_q.res.word == 24'(($past(sum)) >> 1))
		else $error("chopped result is not the pair average");

	temp_select_a: assert property (@(posedge clk) disable iff (!rst_n)
		wr && hit(addr, gcms_pkg::ADDR_SYS)
		|=> temp_sensor_sel == ($past(wdata[gcms_pkg::MON_LSB +: 3]) == gcms_pkg::MON_TEMP)
		&& inputs_disconnect == temp_sensor_sel)
		else $error("temperature sensor selection wrong");

	same_route_a: assert property (@(posedge clk) disable iff (!rst_n)
		wr && hit(addr, gcms_pkg::ADDR_EXC2)
		|=> source_one_route == $past(wdata[3:0]) && source_two_route == $past(wdata[7:4]))
		else $error("current source routing not applied");

	bias_apply_a: assert property (@(posedge clk) disable iff (!rst_n)
		wr && hit(addr, gcms_pkg::ADDR_BIAS) ##1 !(wr && hit(addr, gcms_pkg::ADDR_BIAS))
		|=> bias_level_sel == $past(wdata[7], 2) && bias_pin_connect == $past(wdata[6:0], 2))
		else $error("bias configuration not applied");

	magnitude_a: assert property (@(posedge clk) disable iff (!rst_n)
		wr && hit(addr, gcms_pkg::ADDR_EXC1) |=> excitation_magnitude == $past(wdata[3:0]))
		else $error("excitation magnitude not applied");

endmodule

// ### rtl/gcms_pkg.sv
package gcms_pkg;
	// register offsets, byte-wide plain port
	localparam logic [7:0] ADDR_GAIN = 8'h03;
	localparam logic [7:0] ADDR_RATE = 8'h04;
	localparam logic [7:0] ADDR_EXC1 = 8'h06;
	localparam logic [7:0] ADDR_EXC2 = 8'h07;
	localparam logic [7:0] ADDR_BIAS = 8'h08;
	localparam logic [7:0] ADDR_SYS  = 8'h09;
	localparam logic [7:0] ADDR_CMD  = 8'h0A;
	localparam logic [7:0] ADDR_STAT = 8'h0B;
	localparam logic [7:0] ADDR_RES2 = 8'h0C;
	localparam logic [7:0] ADDR_RES1 = 8'h0D;
	localparam logic [7:0] ADDR_RES0 = 8'h0E;

	// values after reset
	localparam logic [7:0] RST_GAIN = 8'h00;
	localparam logic [7:0] RST_RATE = 8'h00;
	localparam logic [7:0] RST_EXC1 = 8'h00;
	localparam logic [7:0] RST_EXC2 = 8'h00;
	localparam logic [7:0] RST_BIAS = 8'h00;
	localparam logic [7:0] RST_SYS  = 8'h00;

	// field positions
	localparam int RATE_CHOP_BIT  = 5;
	localparam int DELAY_LSB      = 5;
	localparam int MON_LSB        = 5;
	localparam int BIAS_LEVEL_BIT = 7;
	localparam int CMD_START_BIT  = 0;
	localparam int CMD_STOP_BIT   = 1;
	localparam int STAT_READY_BIT = 0;
	localparam int STAT_BUSY_BIT  = 1;

	localparam logic [2:0] MON_TEMP = 3'h2;

	// timing in modulator periods
	localparam int          MODULATOR_PERIOD_CLKS       = 16;
	localparam logic [11:0] DELAY_BASE_MODULATOR_PERIOD = 12'h01C;
	localparam logic [3:0]  LAST_RATE       = 4'hD;
	localparam logic [19:0] FIRST_MODULATOR_PERIOD_DEF [14] = '{
		20'h96082, 20'h4B082, 20'h25882, 20'h16882, 20'h12C82, 20'h07882, 20'h06472,
		20'h03C82, 20'h01E82, 20'h00F82, 20'h00802, 20'h00650, 20'h00350, 20'h001D0};

	typedef enum logic [2:0] {
		GCMS_IDLE  = 3'h1,
		GCMS_FIRST = 3'h2,
		GCMS_NEXT  = 3'h4
	} gcms_seq_e;

	typedef struct packed {
		logic       chop;
		logic [3:0] rate;
		logic [2:0] delay;
	} gcms_cfg_s;

	typedef struct packed {
		logic        toggle;
		logic [23:0] word;
	} gcms_result_s;
endpackage

// ### tb/gcms_filter_model.sv
module gcms_filter_model (
	input  wire logic        conv_clk,
	input  wire logic        rst_n,
	input  wire logic        pol,
	input  var  int          v,
	input  var  int          ofs,
	output logic             raw_valid,
	output logic      [23:0] raw_data
);
	timeunit 1ns;
	timeprecision 1ps;
	int          cnt;
	logic [23:0] last;
	// a conversion ends every 40 link clocks; the offset cancels only if the swap is real
	always @(posedge conv_clk) begin
		if (!rst_n) begin
			cnt <= 0;
			raw_valid <= 1'b0;
			last = 24'h000000;
			raw_data <= 24'hFFFFFF;
		end else begin
			cnt <= (cnt == 39) ? 0 : cnt + 1;
			raw_valid <= (cnt == 39);
			if (cnt == 39)
				last = 24'(pol ? ofs - v : v + ofs);
			// outside the valid cycle the bus shows junk, not the old word
			raw_data <= (cnt == 39) ? last : ~last;
		end
	end
endmodule

// ### tb/global_chop_and_monitor_select_bench.sv
module global_chop_and_monitor_select_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int          TM    = 2;
	localparam int          FT    = 64;
	localparam logic [19:0] FTAB [14] = '{default: 20'h00040};
	localparam int          LIMIT = 60000;
	logic        clk = 1'b0, conv_clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
	logic        start_pin = 1'b0;
	logic [7:0]  addr = 8'h00, wdata = 8'h00, b, rdata;
	logic [7:0]  val [5];
	logic [7:0]  ad [5] = '{gcms_pkg::ADDR_GAIN, gcms_pkg::ADDR_EXC1, gcms_pkg::ADDR_EXC2,
		gcms_pkg::ADDR_BIAS, gcms_pkg::ADDR_SYS};
	logic [7:0]  rv [5] = '{gcms_pkg::RST_GAIN, gcms_pkg::RST_EXC1, gcms_pkg::RST_EXC2,
		gcms_pkg::RST_BIAS, gcms_pkg::RST_SYS};
	logic [3:0]  excitation_magnitude, source_one_route, source_two_route;
	logic [2:0]  amp_gain, monitor_select;
	logic [6:0]  bias_pin_connect;
	logic        bias_level_sel, temp_sensor_sel, inputs_disconnect, chop_polarity;
	logic        result_ready, raw_valid;
	logic [23:0] raw_data, r;
	int          n_fail = 0, compares = 0, cyc = 0, v = 0, ofs = 0, n;
	int          q_exp [$];

	always #2.5 clk = ~clk;
	// link clock with an odd phase offset so the two domains never line up
	initial begin
		#17;
		forever #62.5 conv_clk = ~conv_clk;
	end

	gcms_top #(.MODULATOR_PERIOD_CLKS(TM), .FIRST_MODULATOR_PERIOD(FTAB)) dut_u (.clk, .rst_n, .addr, .wdata, .wr, .rd,
		.rdata, .conv_clk, .start_pin, .raw_valid, .raw_data, .amp_gain, .excitation_magnitude,
		.source_one_route, .source_two_route, .bias_level_sel, .bias_pin_connect,
		.monitor_select, .temp_sensor_sel, .inputs_disconnect, .chop_polarity, .result_ready);

	gcms_filter_model model_u (.conv_clk, .rst_n, .pol(chop_polarity), .v, .ofs, .raw_valid,
		.raw_data);

	task automatic summarize;
		$display("compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	always @(posedge clk) begin
		cyc++;
		if (cyc == LIMIT) begin
			n_fail++;
			summarize();
		end
	end

	task automatic check(input logic [23:0] got, input logic [23:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rreg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask

	task automatic wait_ready(output int k);
		k = 0;
		while (result_ready !== 1'b1 && k < 20000) begin
			@(posedge clk);
			#1 k++;
		end
	endtask

	task automatic read_result(output logic [23:0] res);
		logic [7:0] s;
		rreg(gcms_pkg::ADDR_STAT, s);
		check(24'(s[gcms_pkg::STAT_READY_BIT]), 24'h000001);
		check(24'(s[gcms_pkg::STAT_BUSY_BIT]), 24'h000001);
		rreg(gcms_pkg::ADDR_RES2, res[23:16]);
		rreg(gcms_pkg::ADDR_RES1, res[15:8]);
		rreg(gcms_pkg::ADDR_RES0, res[7:0]);
	endtask

	// a drain gap lets a result already in flight land before ready is cleared
	task automatic stop_run;
		wreg(gcms_pkg::ADDR_CMD, 8'h02);
		repeat (100) @(posedge clk);
		rreg(gcms_pkg::ADDR_STAT, b);
		check(24'(b[gcms_pkg::STAT_BUSY_BIT]), 24'h000000);
	endtask

	task automatic chop_run(input logic [2:0] dc);
		int ft;
		int lt;
		ft = (FT + 2 * (28 << dc)) * TM * 25;
		lt = (FT / 2 + 2 * (28 << dc)) * TM * 25;
		q_exp.push_back(v);
		q_exp.push_back(v);
		wreg(gcms_pkg::ADDR_GAIN, {dc, 5'h01});
		wreg(gcms_pkg::ADDR_RATE, 8'(32'h20 + $urandom_range(13)));
		wreg(gcms_pkg::ADDR_CMD, 8'h01);
		wait_ready(n);
		check(24'(n >= ft && n <= ft + 200), 24'h000001);
		read_result(r);
		check(r, 24'(q_exp.pop_front()));
		wait_ready(n);
		check(24'(n + 8 >= lt - 75 && n + 8 <= lt + 75), 24'h000001);
		read_result(r);
		check(r, 24'(q_exp.pop_front()));
		stop_run();
		$display("chop run with delay code %0d done", dc);
	endtask

	initial begin
		void'($urandom(32'hFC0BA3A0));
		v = int'($urandom_range(60000)) - 30000;
		ofs = int'($urandom_range(2000)) - 1000;
		// reset spans four link clocks so the slow domain sees it too
		repeat (4) @(posedge conv_clk);
		@(posedge clk);
		rst_n <= 1'b1;
		foreach (ad[j]) begin
			rreg(ad[j], b);
			check(24'(b), 24'(rv[j]));
		end
		check(24'(gcms_pkg::FIRST_MODULATOR_PERIOD_DEF[0]), 24'h096082);
		check(24'(gcms_pkg::FIRST_MODULATOR_PERIOD_DEF[6]), 24'h006472);
		check(24'(gcms_pkg::FIRST_MODULATOR_PERIOD_DEF[13]), 24'h0001D0);
		$display("reset values done");
		for (int i = 0; i < 8; i++) begin
			foreach (val[j])
				val[j] = 8'($urandom);
			val[4][7:5] = 3'(i);
			if (i == 2)
				val[0][2:1] = 2'h0;
			if (i == 3)
				val[2][7:4] = val[2][3:0];
			// the reference enable lives outside this block, assumed on here
			foreach (val[j])
				wreg(ad[j], val[j]);
			foreach (val[j]) begin
				rreg(ad[j], b);
				check(24'(b), 24'(val[j]));
			end
			check(24'(amp_gain), 24'(val[0][2:0]));
			check(24'(excitation_magnitude), 24'(val[1][3:0]));
			check(24'({source_two_route, source_one_route}), 24'(val[2]));
			check(24'({bias_level_sel, bias_pin_connect}), 24'(val[3]));
			check(24'(monitor_select), 24'(i));
			check(24'({temp_sensor_sel, inputs_disconnect}), 24'(i == 2 ? 3 : 0));
		end
		$display("register fields done");
		rreg(8'h20, b);
		check(24'(b), 24'h000000);
		wreg(gcms_pkg::ADDR_STAT, 8'hFF);
		rreg(gcms_pkg::ADDR_STAT, b);
		check(24'(b), 24'h000000);
		$display("unmapped access done");
		// bias was written long before any start, standing in for its settling wait
		chop_run(3'h0);
		// a longer settling delay as a host would pick for slow external parts
		chop_run(3'h1);
		wreg(gcms_pkg::ADDR_RATE, 8'h03);
		@(posedge clk);
		start_pin <= 1'b1;
		wait_ready(n);
		check(24'(n <= 1200), 24'h000001);
		read_result(r);
		check(r, 24'(v + ofs));
		check(24'(chop_polarity), 24'h000000);
		start_pin <= 1'b0;
		stop_run();
		$display("pin start without chop done");
		summarize();
	end
endmodule
